/* File: hdl/acs_sequencer.v */
// ADC channel sequencer behind the serial port, oversampling the link pins
`timescale 1ns/1ns
`include "acs_map.vh"
module acs_sequencer
(
  input wire clk,
  input wire arst_n,
  input wire adc_frame_sync_n,
  input wire adc_serial_clock,
  input wire adc_serial_in,
  input wire [11:0] conv_result,
  output reg adc_serial_out_q,
  output reg adc_serial_out_oe_q,
  output reg [3:0] conv_channel_q,
  output reg conv_start_q,
  output reg powerup_dummy_q,
  output reg [1:0] power_mode_q,
  output reg input_range_q,
  output reg straight_binary_q,
  output reg sequence_active_q
);
  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  wire fs_level;
  wire fs_rise;
  wire fs_fall;
  wire sck_level;
  wire sck_rise;
  wire sck_fall;
  wire din_level;

  acs_edge_sync u_fs
  (
    .clk(clk),
    .arst_n(arst_n),
    .pin_in(adc_frame_sync_n),
    .level_q(fs_level),
    .rise(fs_rise),
    .fall(fs_fall)
  );

  acs_edge_sync u_sck
  (
    .clk(clk),
    .arst_n(arst_n),
    .pin_in(adc_serial_clock),
    .level_q(sck_level),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  // Data aligned with clock through the same two-flop depth
  acs_edge_sync u_din
  (
    .clk(clk),
    .arst_n(arst_n),
    .pin_in(adc_serial_in),
    .level_q(din_level),
    .rise(),
    .fall()
  );

  // -----------------------------------------------------------------
  // Sequencer states and decoding
  // -----------------------------------------------------------------
  localparam [2:0] MODE_SINGLE = 3'b001;
  localparam [2:0] MODE_MASK = 3'b010;
  localparam [2:0] MODE_CONSEC = 3'b100;

  // Next enabled channel above cur, wrapping to the lowest enabled one
  function [3:0] next_enabled;
    input [15:0] mask;
    input [3:0] cur;
    input from_start;
    integer i;
    reg found;
    reg [3:0] pick;
    reg [3:0] idx;
    begin
      found = 1'b0;
      pick = 4'h0;
      idx = 4'h0;
      for (i = 1; i <= 16; i = i + 1)
      begin
        idx = from_start ? 4'hf + i[3:0] : cur + i[3:0];
        if (!found && mask[idx])
        begin
          found = 1'b1;
          pick = idx;
        end
      end
      next_enabled = found ? pick : cur;
    end
  endfunction

  reg [10:0] ctrl_q;
  reg [15:0] mask_q;
  reg [15:0] shift_in_q;
  reg [15:0] shift_out_q;
  reg [4:0] edge_cnt_q;
  reg in_frame_q;
  reg mask_armed_q;
  reg mask_start_q;
  reg [2:0] mode_q;
  reg [3:0] addr_q;

  wire [15:0] word_in = {shift_in_q[14:0], din_level};
  wire wr_en = word_in[`ACS_BIT_WRITE];
  wire w_sequence = word_in[`ACS_BIT_SEQUENCE];
  wire w_msel = word_in[`ACS_BIT_MSEL];
  wire last_edge = sck_fall && in_frame_q &&
    (edge_cnt_q == `ACS_EDGE_LAST - 5'd1);

  // -----------------------------------------------------------------
  // Serial shifter: input on falling clock, output while framed
  // -----------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_frame_q <= 1'b0;
      edge_cnt_q <= 5'd0;
      shift_in_q <= 16'h0000;
      shift_out_q <= 16'h0000;
      adc_serial_out_q <= 1'b0;
      adc_serial_out_oe_q <= 1'b0;
    end
    else if (fs_fall)
    begin
      // Result word leads with the channel it belongs to
      in_frame_q <= 1'b1;
      edge_cnt_q <= 5'd0;
      shift_out_q <= {conv_channel_q, conv_result};
      adc_serial_out_q <= conv_channel_q[3];
      adc_serial_out_oe_q <= 1'b1;
    end
    else if (fs_rise && in_frame_q)
    begin
      in_frame_q <= 1'b0;
      adc_serial_out_oe_q <= ctrl_q[`ACS_BIT_WEAK];
    end
    else if (sck_fall && in_frame_q &&
             edge_cnt_q != `ACS_EDGE_LAST)
    begin
      shift_in_q <= word_in;
      edge_cnt_q <= edge_cnt_q + 5'd1;
      shift_out_q <= {shift_out_q[14:0], 1'b0};
      adc_serial_out_q <= shift_out_q[14];
      if (last_edge)
        adc_serial_out_oe_q <= ctrl_q[`ACS_BIT_WEAK];
    end
  end

  // -----------------------------------------------------------------
  // Control, mask and mode, updated at the end of each 16-edge word
  // -----------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_q <= `ACS_CTRL_RESET;
      mask_q <= `ACS_MASK_RESET;
      mask_armed_q <= 1'b0;
      mask_start_q <= 1'b0;
      mode_q <= MODE_SINGLE;
      addr_q <= 4'h0;
    end
    else if (last_edge)
    begin
      if (mask_armed_q)
      begin
        // Word after a write with msel set and sequence clear is mask data, not control
        mask_q <= word_in;
        mask_armed_q <= 1'b0;
        mask_start_q <= 1'b1;
        mode_q <= MODE_MASK;
      end
      else if (wr_en)
      begin
        ctrl_q <= word_in[10:0];
        addr_q <= word_in[`ACS_ADDR_HI:`ACS_ADDR_LO];
        mask_armed_q <= ~w_sequence & w_msel;
        case ({w_sequence, w_msel})
          2'b00: mode_q <= MODE_SINGLE;
          2'b10: mode_q <= mode_q;
          2'b11:
          begin
            mode_q <= MODE_CONSEC;
            mask_start_q <= 1'b1;
          end
          default: mode_q <= MODE_SINGLE;
        endcase
      end
    end
    else if (fs_fall)
      mask_start_q <= 1'b0;
  end

  // -----------------------------------------------------------------
  // Channel selection for the next conversion
  // -----------------------------------------------------------------
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      conv_channel_q <= 4'h0;
      conv_start_q <= 1'b0;
      powerup_dummy_q <= 1'b0;
      power_mode_q <= 2'b11;
      input_range_q <= 1'b0;
      straight_binary_q <= 1'b0;
      sequence_active_q <= 1'b0;
    end
    else
    begin
      conv_start_q <= fs_fall;
      power_mode_q <= ctrl_q[`ACS_BIT_PWR_HI:`ACS_BIT_PWR_LO];
      input_range_q <= ctrl_q[`ACS_BIT_RANGE];
      straight_binary_q <= ctrl_q[`ACS_BIT_CODING];
      sequence_active_q <= (mode_q != MODE_SINGLE);
      // Autostandby wakes within one dummy cycle before converting
      if (fs_fall)
        powerup_dummy_q <=
          (ctrl_q[`ACS_BIT_PWR_HI:`ACS_BIT_PWR_LO] == 2'b00);
      if (fs_fall)
      begin
        case (mode_q)
          MODE_SINGLE: conv_channel_q <= addr_q;
          MODE_MASK:
            conv_channel_q <=
              next_enabled(mask_q, conv_channel_q, mask_start_q);
          MODE_CONSEC:
            if (mask_start_q || conv_channel_q >= addr_q)
              conv_channel_q <= 4'h0;
            else
              conv_channel_q <= conv_channel_q + 4'h1;
          default: conv_channel_q <= addr_q;
        endcase
      end
    end
  end
endmodule // acs_sequencer

/* File: hdl/acs_map.vh */
// Constants for the ADC channel sequencer: control word layout and timing
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_WORD_BITS 16
`define ACS_BIT_WRITE 11
`define ACS_BIT_SEQUENCE 10
`define ACS_ADDR_HI 9
`define ACS_ADDR_LO 6
`define ACS_BIT_PWR_HI 5
`define ACS_BIT_PWR_LO 4
`define ACS_BIT_MSEL 3
`define ACS_BIT_WEAK 2
`define ACS_BIT_RANGE 1
`define ACS_BIT_CODING 0
`define ACS_CTRL_RESET 11'h030
`define ACS_MASK_RESET 16'h0000
`define ACS_ADDR_EDGE 5'd14
`define ACS_EDGE_LAST 5'd16
`endif

/* File: hdl/acs_edge_sync.v */
// Two-flop synchroniser with edge detection for one external pin
`timescale 1ns/1ns
module acs_edge_sync
(
  input wire clk,
  input wire arst_n,
  input wire pin_in,
  output reg level_q,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg last_q;

  // First flop feeds only the second one
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= 1'b1;
      level_q <= 1'b1;
      last_q <= 1'b1;
    end
    else
    begin
      meta_q <= pin_in;
      level_q <= meta_q;
      last_q <= level_q;
    end
  end

  // Edges seen on the synchronised level only
  assign rise = level_q & ~last_q;
  assign fall = ~level_q & last_q;
endmodule // acs_edge_sync

/* File: tb/acs_sequencer_asserts.sv */
// Port-level checks for the channel sequencer
`timescale 1ns/1ns
module acs_sequencer_asserts
(
  input wire clk,
  input wire arst_n,
  input wire adc_frame_sync_n,
  input wire adc_serial_out_oe_q,
  input wire [3:0] conv_channel_q,
  input wire conv_start_q,
  input wire powerup_dummy_q,
  input wire [1:0] power_mode_q,
  input wire input_range_q,
  input wire straight_binary_q,
  input wire sequence_active_q
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // Frame start: pulse, channel and driver enable
  AST_START_LATE:
    assert property ($fell(adc_frame_sync_n) |-> ##[2:5] conv_start_q)
    else $error("no start after frame fall");
  AST_START_ONE:
    assert property (conv_start_q |=> !conv_start_q [*8])
    else $error("start pulse too long or too close");
  AST_START_IN_FRAME:
    assert property (conv_start_q |-> !adc_frame_sync_n)
    else $error("start outside a frame");
  AST_CHAN_AT_START:
    assert property ($changed(conv_channel_q) |-> conv_start_q)
    else $error("channel moved without a start");
  AST_OE_AT_FRAME:
    assert property ($fell(adc_frame_sync_n) |-> ##[1:5] adc_serial_out_oe_q)
    else $error("serial out not driven in frame");
  // Control fields only move at the end of a word, inside a frame
  AST_PM_IN_FRAME:
    assert property ($changed(power_mode_q) |-> !adc_frame_sync_n)
    else $error("power mode moved between frames");
  AST_SEQUENCE_IN_FRAME:
    assert property ($changed(sequence_active_q) |-> !adc_frame_sync_n)
    else $error("sequence state moved between frames");
  AST_BITS_IN_FRAME:
    assert property ($changed({input_range_q, straight_binary_q})
      |-> !adc_frame_sync_n)
    else $error("range or coding moved between frames");
  // Main scenarios reached
  COV_SEQUENCE_START: cover property (conv_start_q && sequence_active_q);
  COV_DUMMY: cover property (conv_start_q && powerup_dummy_q);
  COV_TOP_CH: cover property (conv_start_q && conv_channel_q == 4'hf);
endmodule // acs_sequencer_asserts

bind acs_sequencer acs_sequencer_asserts acs_sequencer_asserts_i (
  .clk(clk), .arst_n(arst_n), .adc_frame_sync_n(adc_frame_sync_n),
  .adc_serial_out_oe_q(adc_serial_out_oe_q), .conv_channel_q(conv_channel_q),
  .conv_start_q(conv_start_q), .powerup_dummy_q(powerup_dummy_q),
  .power_mode_q(power_mode_q), .input_range_q(input_range_q),
  .straight_binary_q(straight_binary_q),
  .sequence_active_q(sequence_active_q));

/* File: tb/acs_host_model.sv */
// Host serial controller model driving the sequencer link pins
`timescale 1ns/1ns
module acs_host_model
(
  input wire clk,
  input wire sdo,
  output reg fs_n = 1'b1,
  output reg sck = 1'b1,
  output reg sdi = 1'b0
);
  // One 16-bit frame, 160 ns per bit; clock parked high between frames
  task xfer(input [15:0] w, output [15:0] r);
    integer i;
    begin
      @(negedge clk) fs_n <= 1'b0;
      repeat (4) @(negedge clk);
      for (i = 15; i >= 0; i = i - 1)
      begin
        sdi <= w[i];
        repeat (4) @(negedge clk);
        r[i] = sdo;
        sck <= 1'b0;
        repeat (4) @(negedge clk);
        sck <= 1'b1;
      end
      // Hold sync past the word end so the update lands inside the frame
      repeat (8) @(negedge clk);
      fs_n <= 1'b1;
      sdi <= ~sdi;
      repeat (8) @(negedge clk);
    end
  endtask
endmodule // acs_host_model

/* File: tb/acs_sequencer_tb.sv */
// Self-checking bench for the channel sequencer
`timescale 1ns/1ns
module acs_sequencer_tb;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg [11:0] res = 12'h000;
  reg [31:0] lfsr = 32'hc1774885;
  reg [5:0] q [$];
  reg [5:0] e;
  reg [15:0] r;
  wire fs_n, sck, sdi, sdo, start, dum, oe, act, rng, sb;
  wire [1:0] pm;
  wire [3:0] ch;
  integer miscompares = 0;
  integer n_compared = 0;
  integer k;
  // Clock, device and host
  always #10 clk = ~clk;
  acs_sequencer acs_sequencer_i (.clk(clk), .arst_n(arst_n),
    .adc_frame_sync_n(fs_n), .adc_serial_clock(sck), .adc_serial_in(sdi),
    .conv_result(res), .adc_serial_out_q(sdo), .adc_serial_out_oe_q(oe),
    .conv_channel_q(ch), .conv_start_q(start), .powerup_dummy_q(dum),
    .power_mode_q(pm), .input_range_q(rng), .straight_binary_q(sb),
    .sequence_active_q(act));
  acs_host_model acs_host_model_i (.clk(clk), .sdo(sdo), .fs_n(fs_n),
    .sck(sck), .sdi(sdi));
  // Control word: write bit set, then seq, address, power, select
  function [15:0] w(input s, input [3:0] a, input m, input [1:0] p);
    w = {5'h01, s, a, p, m, 3'h0};
  endfunction
  // Random word with the write bit clear
  function [15:0] rw();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    rw = lfsr[15:0] & 16'hf7ff;
  endfunction
  task cmp(input string nm, input [15:0] x, input [15:0] g);
    n_compared = n_compared + 1;
    if (g !== x)
    begin
      miscompares = miscompares + 1;
      $display("wrong value %s exp %h got %h", nm, x, g);
    end
  endtask
  // Expectation: bit 5 dummy, bit 4 skip channel, bits 3:0 channel
  task frame(input [15:0] wd, input [5:0] x);
    r = rw();
    @(negedge clk) res <= r[11:0];
    q.push_back(x);
    acs_host_model_i.xfer(wd, r);
    cmp("result", {4'h0, res}, {4'h0, r[11:0]});
  endtask
  // Watcher: each start pulse consumes the oldest expectation
  always @(negedge clk)
    if (start === 1'b1)
    begin
      if (q.size() == 0)
        miscompares = miscompares + 1;
      else
      begin
        e = q.pop_front();
        if (!e[4])
          cmp("channel", {12'h000, e[3:0]}, {12'h000, ch});
        cmp("dummy", {15'h0000, e[5]}, {15'h0000, dum});
      end
    end
  // Control outputs between frames: oe, active, power, range, coding
  task ctl(input [5:0] x);
    cmp("control", {10'h000, x}, {10'h000, oe, act, pm, rng, sb});
  endtask
  task tally_and_finish;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    repeat (6) @(negedge clk);
    arst_n <= 1'b1;
    repeat (4) @(negedge clk);
    frame(w(0, 4'h5, 0, 2'h3), 6'h00);
    ctl(6'h0c);
    frame(w(0, 4'h9, 1, 2'h3), 6'h05);
    frame(16'h8421, 6'h10);
    frame(rw(), 6'h00);
    frame(rw(), 6'h05);
    frame(w(1, 4'h3, 0, 2'h0), 6'h0a);
    ctl(6'h10);
    frame(rw(), 6'h2f);
    frame(w(1, 4'h3, 0, 2'h3), 6'h20);
    frame(w(1, 4'h2, 1, 2'h3), 6'h05);
    ctl(6'h1c);
    frame(rw(), 6'h00);
    frame(rw(), 6'h01);
    frame(rw(), 6'h02);
    frame(w(0, 4'h7, 0, 2'h3), 6'h00);
    ctl(6'h0c);
    frame(rw(), 6'h07);
    frame(rw(), 6'h07);
    // Bounded drain of pending expectations
    k = 0;
    while (q.size() != 0 && k < 20)
    begin
      @(negedge clk);
      k = k + 1;
    end
    if (q.size() != 0)
      miscompares = miscompares + 1;
    tally_and_finish;
  end
endmodule // acs_sequencer_tb
